// File: core/ofs_pkg.sv
// Purpose: Shared constants of the offline start-up supervisor.
// Assumes: 25 MHz core clock; 65 kHz frequency option.
// Notes:   Times are kept in their own unit, cycle counts derive from them.
package ofs_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Clock
   localparam int CLK_HZ  = 25_000_000;   // Core clock rate
   localparam int CLK_MHZ = 25;           // Core clock in MHz

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator and jitter
   localparam int FOSC_HZ     = 65_000;   // Nominal switching frequency
   localparam int JIT_DEV_HZ  = 4_000;    // Peak frequency deviation
   localparam int JIT_MOD_HZ  = 125;      // Triangle modulation rate
   localparam int JIT_STEPS   = 64;       // Steps per triangle half period
   localparam int JIT_DIV_CYC = CLK_HZ / (JIT_MOD_HZ * 2 * JIT_STEPS);
   localparam int DUTY_PCT    = 80;       // Maximum duty ratio in percent
   localparam logic [31:0] OSC_INC =
      32'((64'(FOSC_HZ) << 32) / 64'(CLK_HZ));
   localparam logic [31:0] DEV_INC =
      32'((64'(JIT_DEV_HZ) << 32) / 64'(CLK_HZ));
   localparam logic [31:0] JIT_INC = 32'(2 * DEV_INC / JIT_STEPS);
   localparam logic [31:0] DUTY_LIM = 32'(((64'd1 << 32) * DUTY_PCT) / 100);

   ////////////////////////////////////////////////////////////////////////////
   // Soft start: 32 set-point steps over the soft-start time
   localparam int SS_US       = 4000;     // Soft-start time in us
   localparam int SS_STEPS    = 32;       // Number of set-point steps
   localparam int SS_STEP_CYC = SS_US * CLK_MHZ / SS_STEPS;

   ////////////////////////////////////////////////////////////////////////////
   // Long timers, used as defaults of top-level parameters
   localparam int SAMPLE_US  = 1000;      // Line sampling period in us
   localparam int DETECT_US  = 32000;     // Unplug detection time in us
   localparam int DROPOUT_US = 20000;     // Line drop-out filter time in us
   localparam int GTOM_US    = 2000;      // Go-to-off-mode time in us
   localparam int SAMPLE_CYC  = SAMPLE_US * CLK_MHZ;
   localparam int DETECT_CYC  = DETECT_US * CLK_MHZ;
   localparam int DROPOUT_CYC = DROPOUT_US * CLK_MHZ;
   localparam int GTOM_CYC    = GTOM_US * CLK_MHZ;
   localparam int CNT_W       = 24;       // Width of the long counters
   localparam int NSYNC       = 11;       // Number of synchronised inputs

   // Operating states of the supervisor
   typedef enum logic [2:0] {
      ST_OFF, ST_IDLE, ST_ARMED, ST_SOFT, ST_RUN
   } ofs_state_t;
endpackage : ofs_pkg

// File: core/ofs_supervisor.sv
// Purpose: Start-up, brown-out, unplug discharge, off mode and oscillator.
// Assumes: Comparator outputs are levels; watchdog_in is a one-cycle pulse.
// Notes:   Fault latch survives off mode and is cleared only by reset.
`timescale 1ns/10ps

module ofs_supervisor #(
   parameter int SAMPLE_CYC  = ofs_pkg::SAMPLE_CYC,  // Sampling period
   parameter int DETECT_CYC  = ofs_pkg::DETECT_CYC,  // Detection timer
   parameter int DROPOUT_CYC = ofs_pkg::DROPOUT_CYC, // Drop-out filter
   parameter int GTOM_CYC    = ofs_pkg::GTOM_CYC     // Off mode entry filter
) (
   input  wire logic       core_clk_in,           // 25 MHz clock
   input  wire logic       nrst_in,               // Async reset, active low
   input  wire logic       supply_turnon_in,      // Supply at turn-on level
   input  wire logic       supply_restart_in,     // Supply below restart level
   input  wire logic       supply_turnoff_in,     // Supply below turn-off level
   input  wire logic       supply_inhibit_in,     // Supply above inhibit level
   input  wire logic       supply_overvolt_in,    // Supply overvoltage
   input  wire logic       line_min_in,           // Line above minimum level
   input  wire logic       line_start_in,         // Line above start level
   input  wire logic       line_stop_in,          // Line below stop level
   input  wire logic       unplug_cmp_in,         // Unplug detector comparator
   input  wire logic       fb_off_in,             // Feedback below off level
   input  wire logic       fb_wake_in,            // Feedback above wake level
   input  wire logic       thermal_shutdown_in,   // Die overtemperature
   input  wire logic       watchdog_in,           // Watchdog event pulse
   output logic            charge_en_out,         // Start-up source enable
   output logic            charge_low_out,        // Reduced charging current
   output logic            discharge_out,         // Discharge current select
   output logic            sample_hold_out,       // Sample-and-hold strobe
   output logic            dc_detect_out,         // Line unplugged flag
   output logic            gate_drive_out,        // Gate drive
   output logic [4:0]      softstart_level_out,   // Current limit step
   output logic            softstart_done_out,    // Regulation has control
   output logic            brownout_out,          // Brown-out flag
   output logic            fault_latched_out,     // Latched fault flag
   output logic            off_mode_out,          // In off mode
   output logic            internal_supply_out    // Internal supply enabled
);
   localparam int CW = ofs_pkg::CNT_W;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers, two flops per comparator
   logic [ofs_pkg::NSYNC-1:0] raw;     // Raw comparator vector
   logic [ofs_pkg::NSYNC-1:0] meta;    // First stage, read by second only
   logic [ofs_pkg::NSYNC-1:0] sy;      // Synchronised vector
   assign raw = {supply_turnon_in, supply_restart_in, supply_turnoff_in,
                 supply_inhibit_in, supply_overvolt_in, line_min_in,
                 line_start_in, line_stop_in, unplug_cmp_in, fb_off_in,
                 fb_wake_in};

   genvar gi;
   generate
      for (gi = 0; gi < ofs_pkg::NSYNC; gi++) begin : g_sync
         // Each bit through its own two-flop chain
         always_ff @(posedge core_clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               meta[gi] <= 1'b0;
               sy[gi]   <= 1'b0;
            end else begin
               meta[gi] <= raw[gi];
               sy[gi]   <= meta[gi];
            end
         end
      end
   endgenerate

   logic s_on, s_rst, s_toff, s_inh, s_ovp, s_lmin, s_lstart, s_lstop;
   logic s_cmp, s_fboff, s_fbwake;
   assign {s_on, s_rst, s_toff, s_inh, s_ovp, s_lmin, s_lstart, s_lstop,
           s_cmp, s_fboff, s_fbwake} = sy;

   logic on_d;                         // Delayed turn-on for edge detect
   logic cmp_d;                        // Delayed comparator for edges
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         on_d  <= 1'b0;
         cmp_d <= 1'b0;
      end else begin
         on_d  <= s_on;
         cmp_d <= s_cmp;
      end
   end
   logic on_rise;                      // Supply just reached turn-on
   logic cmp_edge;                     // Any comparator edge means ac
   assign on_rise  = s_on & ~on_d;
   assign cmp_edge = s_cmp ^ cmp_d;

   ////////////////////////////////////////////////////////////////////////////
   // Unplug detector: sample strobe, detection timer, cyclic discharge
   logic [CW-1:0] smp_cnt;             // Sampling period counter
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         smp_cnt         <= '0;
         sample_hold_out <= 1'b0;
      end else if (smp_cnt == CW'(SAMPLE_CYC - 1)) begin
         smp_cnt         <= '0;
         sample_hold_out <= 1'b1;
      end else begin
         smp_cnt         <= smp_cnt + 1'b1;
         sample_hold_out <= 1'b0;
      end
   end

   logic [CW-1:0] det_cnt;             // Detection timer, reused for discharge
   logic          det_end;             // Detection timer elapses
   logic          dis_phase;           // Discharge half of the cycle
   assign det_end = (det_cnt == CW'(DETECT_CYC - 1));

   // Runs in every state so discharge is never disabled by mode
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         det_cnt       <= '0;
         dc_detect_out <= 1'b0;
         dis_phase     <= 1'b0;
      end else if (cmp_edge) begin
         det_cnt       <= '0;
         dc_detect_out <= 1'b0;
         dis_phase     <= 1'b0;
      end else if (det_end) begin
         det_cnt       <= '0;
         dc_detect_out <= 1'b1;
         // First expiry starts discharge, later ones alternate with sensing
         dis_phase     <= ~dc_detect_out | ~dis_phase;
      end else begin
         det_cnt       <= det_cnt + 1'b1;
      end
   end

   // Discharge stops once the capacitor is below the minimum line level
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         discharge_out <= 1'b0;
      end else begin
         discharge_out <= dis_phase & dc_detect_out & s_lmin;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode state machine
   ofs_pkg::ofs_state_t state;         // Current mode
   logic [CW-1:0] drop_cnt;            // Line drop-out timer
   logic [CW-1:0] gtom_cnt;            // Go-to-off-mode timer
   logic          drop_end;            // Drop-out confirmed
   logic          gtom_end;            // Feedback low long enough
   logic          wd_wait;             // Restart held for a watchdog event
   logic          switching;           // Soft start or run
   logic [CW-1:0] ss_cnt;              // Soft-start step divider
   logic          ss_tick;             // One soft-start step elapsed
   assign switching = (state == ofs_pkg::ST_SOFT) | (state == ofs_pkg::ST_RUN);
   assign drop_end  = (drop_cnt == CW'(DROPOUT_CYC - 1));
   assign gtom_end  = (gtom_cnt == CW'(GTOM_CYC - 1));
   assign ss_tick   = (ss_cnt == CW'(ofs_pkg::SS_STEP_CYC - 1));

   // Drop-out timer runs only while line sits below the stop level
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         drop_cnt <= '0;
      end else if (!switching || !s_lstop || drop_end) begin
         drop_cnt <= '0;
      end else begin
         drop_cnt <= drop_cnt + 1'b1;
      end
   end

   // Brief feedback dips restart the off mode filter
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gtom_cnt <= '0;
      end else if (state == ofs_pkg::ST_OFF || !s_fboff || gtom_end) begin
         gtom_cnt <= '0;
      end else begin
         gtom_cnt <= gtom_cnt + 1'b1;
      end
   end

   // Overvoltage latch; kept across off mode, cleared only by reset
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         fault_latched_out <= 1'b0;
      end else if (s_ovp) begin
         fault_latched_out <= 1'b1;
      end
   end

   // Watchdog wait: set by drop-out stop, set wins over clear
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wd_wait <= 1'b0;
      end else if (drop_end) begin
         wd_wait <= 1'b1;
      end else if (watchdog_in) begin
         wd_wait <= 1'b0;
      end
   end

   // Brown-out flag holds until the line is back above start
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         brownout_out <= 1'b0;
      end else if (drop_end) begin
         brownout_out <= 1'b1;
      end else if (s_lstart) begin
         brownout_out <= 1'b0;
      end
   end

   // Mode transitions; thermal and feedback off take every state to off
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= ofs_pkg::ST_OFF;
      end else if (thermal_shutdown_in || gtom_end) begin
         state <= ofs_pkg::ST_OFF;
      end else begin
         case (state)
            ofs_pkg::ST_OFF: begin
               if (s_fbwake) begin
                  state <= ofs_pkg::ST_IDLE;
               end
            end
            ofs_pkg::ST_IDLE: begin
               // Start level armed only without fault or watchdog hold
               if (s_lstart && !wd_wait && !fault_latched_out) begin
                  state <= ofs_pkg::ST_ARMED;
               end
            end
            ofs_pkg::ST_ARMED: begin
               if (fault_latched_out) begin
                  state <= ofs_pkg::ST_IDLE;
               end else if (on_rise && !dc_detect_out) begin
                  state <= ofs_pkg::ST_SOFT;
               end
            end
            ofs_pkg::ST_SOFT, ofs_pkg::ST_RUN: begin
               if (fault_latched_out || drop_end) begin
                  state <= ofs_pkg::ST_IDLE;
               end else if (state == ofs_pkg::ST_SOFT && ss_tick &&
                            softstart_level_out == 5'h1f) begin
                  state <= ofs_pkg::ST_RUN;
               end
            end
            default: begin
               state <= ofs_pkg::ST_OFF;
            end
         endcase
      end
   end

   // Soft-start staircase of 32 current-limit steps
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ss_cnt              <= '0;
         softstart_level_out <= 5'h00;
      end else if (state != ofs_pkg::ST_SOFT) begin
         ss_cnt              <= '0;
         softstart_level_out <= 5'h00;
      end else if (ss_tick) begin
         ss_cnt              <= '0;
         softstart_level_out <= softstart_level_out + 5'h01;
      end else begin
         ss_cnt              <= ss_cnt + 1'b1;
      end
   end

   // Status flags registered from the mode
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         softstart_done_out  <= 1'b0;
         off_mode_out        <= 1'b1;
         internal_supply_out <= 1'b0;
      end else begin
         softstart_done_out  <= (state == ofs_pkg::ST_RUN);
         off_mode_out        <= (state == ofs_pkg::ST_OFF);
         internal_supply_out <= (state != ofs_pkg::ST_OFF);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self-supply: hysteretic start-up source control
   logic low_limit;                    // Supply at the lower hysteresis bound
   // Off mode and discharge hold only above turn-off, otherwise restart
   assign low_limit = (off_mode_out | dc_detect_out) ? s_toff : s_rst;

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         charge_en_out <= 1'b0;
      end else if (!s_lmin) begin
         charge_en_out <= 1'b0;
      end else if (s_on) begin
         charge_en_out <= 1'b0;
      end else if (low_limit || !s_inh || state == ofs_pkg::ST_IDLE && !on_d) begin
         charge_en_out <= 1'b1;
      end
   end

   // Shorted supply pin is fed the reduced current
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         charge_low_out <= 1'b1;
      end else begin
         charge_low_out <= ~s_inh;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator: phase accumulator with triangle jitter on its increment
   logic [31:0] phase;                 // Oscillator phase
   logic [CW-1:0] jit_div;             // Triangle step divider
   logic [6:0]  tri_pos;               // Triangle position 0..JIT_STEPS
   logic        tri_up;                // Triangle direction
   logic [31:0] next_inc;              // Phase increment with jitter
   assign next_inc = ofs_pkg::OSC_INC - ofs_pkg::DEV_INC +
                     32'(tri_pos) * ofs_pkg::JIT_INC;

   // Jitter stays independent of any load-dependent frequency change
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         jit_div <= '0;
         tri_pos <= 7'h00;
         tri_up  <= 1'b1;
      end else if (jit_div == CW'(ofs_pkg::JIT_DIV_CYC - 1)) begin
         jit_div <= '0;
         if (tri_up) begin
            tri_pos <= tri_pos + 7'h01;
            tri_up  <= (tri_pos != 7'(ofs_pkg::JIT_STEPS - 1));
         end else begin
            tri_pos <= tri_pos - 7'h01;
            tri_up  <= (tri_pos == 7'h01);
         end
      end else begin
         jit_div <= jit_div + 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase <= 32'h0000_0000;
      end else begin
         phase <= phase + next_inc;
      end
   end

   // Drive only while switching, no fault, and within the duty limit
   always_ff @(posedge core_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gate_drive_out <= 1'b0;
      end else begin
         gate_drive_out <= switching & ~fault_latched_out & ~s_ovp &
                           (phase < ofs_pkg::DUTY_LIM);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   chk_ovp_stops_drive: assert property (s_ovp |=> !gate_drive_out)
      else $error("drive active after overvoltage");
   chk_fault_sticky: assert property (s_ovp || fault_latched_out |=> fault_latched_out)
      else $error("fault latch lost");
   chk_low_current: assert property (!s_inh |=> charge_low_out)
      else $error("full current below inhibit level");
   chk_no_charge_lowline: assert property (!s_lmin |=> !charge_en_out)
      else $error("source on with line below minimum");
   chk_off_no_drive: assert property (off_mode_out |-> !gate_drive_out)
      else $error("drive in off mode");
   chk_edge_clears_dc: assert property (cmp_edge |=> !dc_detect_out)
      else $error("dc flag after comparator edge");
   chk_start_on_edge: assert property (
      state == ofs_pkg::ST_ARMED ##1 state == ofs_pkg::ST_SOFT |-> $past(on_rise))
      else $error("start without turn-on edge");
   chk_discharge_blocks: assert property (
      state == ofs_pkg::ST_ARMED && dc_detect_out && !thermal_shutdown_in
      && !gtom_end && !fault_latched_out |=> state == ofs_pkg::ST_ARMED)
      else $error("start during discharge");
   chk_sample_period: assert property (
      sample_hold_out |=> !sample_hold_out [*8])
      else $error("sample strobe too frequent");
   chk_thermal_off: assert property (thermal_shutdown_in |=> ##1 off_mode_out)
      else $error("thermal did not enter off mode");

   cov_reach_run: cover property (state == ofs_pkg::ST_RUN);
   cov_brownout: cover property ($rose(brownout_out));
   cov_discharge: cover property ($rose(discharge_out));
   cov_off_wake: cover property (state == ofs_pkg::ST_OFF ##1 state == ofs_pkg::ST_IDLE);
endmodule : ofs_supervisor

// File: tb/ofs_cmp_model.sv
// Purpose: Pin comparators of supply, line and feedback
// Assumes: Supply and feedback in mV, line in volts
// Notes:   Thresholds are plain defaults, not trimmed values
`timescale 1ns/10ps
module ofs_cmp_model #(
   parameter int TON = 12000, RST = 9000, TOF = 8000, INH = 1000, // Supply levels
   parameter int OVP = 28000, LMIN = 40, LSTA = 103, LSTO = 100   // Overvoltage and line levels
) (
   input  wire logic        clk_in,  // Core clock
   input  wire integer      vcc_in,  // Supply level
   input  wire integer      line_in, // Line level
   input  wire integer      fb_in,   // Feedback level
   input  wire logic        ac_in,   // Ac line present
   output logic [10:0]      cmp_out  // Comparator outputs
);
   logic [2:0] ph = 3'h0; // Ripple phase
   logic       up = 1'b0; // Unplug detector output
   // Ac ripple makes edges; dc leaves the detector low, as it has no hysteresis
   always_ff @(posedge clk_in) begin
      ph <= ph + 3'h1;
      up <= ac_in & ph[2];
   end
   assign cmp_out = {vcc_in >= TON, vcc_in < RST, vcc_in < TOF, vcc_in > INH,
      vcc_in > OVP, line_in > LMIN, line_in > LSTA, line_in < LSTO, up,
      fb_in < 600, fb_in > 2200};
endmodule : ofs_cmp_model

// File: tb/test_offline_startup_supervisor.sv
// Purpose: Self-checking bench of the start-up supervisor
// Assumes: Shortened timers; pins come from the comparator model
// Notes:   Expectations follow from the pin levels the bench sets
`timescale 1ns/10ps
module test_offline_startup_supervisor;
   localparam int DET = 200, DRO = 100, GTO = 50; // Shortened timers
   logic core_clk_in = 1'b0;                      // 25 MHz clock
   logic nrst_in = 1'b0;                          // Reset, active low
   int vcc = 500, line = 0, fb = 1000;            // Pin levels
   logic ac = 1'b1, therm = 1'b0, wd = 1'b0;      // Other inputs
   logic [10:0] c;                                // Comparator bits
   logic cen, clo, dis, dcd, gd, ssd, bo, flt, off, isup, pg, sh; // Outputs; pg holds the previous gate value
   logic seen = 1'b0;                             // Gate was seen high
   logic [4:0] ssl;                               // Soft-start step
   int n_errors = 0, n_checks = 0, cyc = 0, hi, ed, ns; // Counters
   ofs_cmp_model MDL (.clk_in(core_clk_in), .vcc_in(vcc), .line_in(line), .fb_in(fb),
      .ac_in(ac), .cmp_out(c));
   ofs_supervisor #(.SAMPLE_CYC(20), .DETECT_CYC(DET), .DROPOUT_CYC(DRO), .GTOM_CYC(GTO)) DUT (
      .core_clk_in(core_clk_in), .nrst_in(nrst_in), .supply_turnon_in(c[10]),
      .supply_restart_in(c[9]), .supply_turnoff_in(c[8]), .supply_inhibit_in(c[7]),
      .supply_overvolt_in(c[6]), .line_min_in(c[5]), .line_start_in(c[4]),
      .line_stop_in(c[3]), .unplug_cmp_in(c[2]), .fb_off_in(c[1]), .fb_wake_in(c[0]),
      .thermal_shutdown_in(therm), .watchdog_in(wd), .charge_en_out(cen),
      .charge_low_out(clo), .discharge_out(dis), .sample_hold_out(sh), .dc_detect_out(dcd),
      .gate_drive_out(gd), .softstart_level_out(ssl), .softstart_done_out(ssd),
      .brownout_out(bo), .fault_latched_out(flt), .off_mode_out(off),
      .internal_supply_out(isup));
   //////////////////////////////////////////////////////////////
   initial forever #20 core_clk_in = ~core_clk_in;
   // Remember any drive pulse, so quiet stretches can be checked at once
   always @(posedge core_clk_in) if (gd === 1'b1) seen <= 1'b1;
   // Hang guard, far above the length of the sequence
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 30000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : step
   task automatic chk(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Supply dips below turn-on and comes back: a fresh turn-on event
   task automatic vcc_edge();
      vcc = 10000;
      step(5);
      vcc = 12500;
   endtask : vcc_edge
   //////////////////////////////////////////////////////////////
   initial begin
      hi = $urandom(32'h7a24);
      step(16);
      chk(off, 1'b1);
      chk(gd, 1'b0);
      nrst_in = 1'b1;
      step(6);
      chk(off, 1'b1);
      chk(cen, 1'b0);
      chk(clo, 1'b1);
      line = 50;
      step(6);
      chk(cen, 1'b1);
      vcc = 5000;
      step(6);
      chk(clo, 1'b0);
      chk(cen, 1'b1);
      fb = 3000;
      vcc = 12500;
      step(6);
      chk(off, 1'b0);
      chk(cen, 1'b0);
      line = 120;
      seen = 1'b0;
      step(500);
      chk(seen, 1'b0);
      vcc_edge();
      step(3140);
      chk(seen, 1'b1);
      chk(ssl === 5'h01, 1'b1);
      chk(ssd, 1'b0);
      hi = 0;
      ed = 0;
      ns = 0;
      pg = gd;
      // A 20-cycle strobe gives exactly 100 pulses in any 2000-cycle window
      repeat (2000) begin
         step(1);
         hi += int'(gd === 1'b1);
         ed += int'(gd === 1'b1 && pg === 1'b0);
         ns += int'(sh === 1'b1);
         pg = gd;
      end
      chk(ns == 100, 1'b1);
      chk(hi >= 1500 && hi <= 1700, 1'b1);
      chk(ed >= 4 && ed <= 6, 1'b1);
      line = 80;
      step(20 + $urandom % 50);
      line = 120;
      step(6);
      chk(bo, 1'b0);
      line = 80;
      step(DRO + 10);
      chk(bo, 1'b1);
      seen = 1'b0;
      step(400);
      chk(seen, 1'b0);
      line = 120;
      vcc_edge();
      step(500);
      chk(bo, 1'b0);
      chk(seen, 1'b0);
      wd = 1'b1;
      step(1);
      wd = 1'b0;
      vcc_edge();
      step(600);
      chk(seen, 1'b1);
      ac = 1'b0;
      step(DET - 20);
      chk(dcd, 1'b0);
      step(40);
      chk(dcd, 1'b1);
      chk(dis, 1'b1);
      ac = 1'b1;
      step(20);
      chk(dcd, 1'b0);
      chk(dis, 1'b0);
      fb = 300;
      step(5 + $urandom % 30);
      fb = 3000;
      step(6);
      chk(off, 1'b0);
      fb = 300;
      step(GTO + 10);
      chk(off, 1'b1);
      chk(isup, 1'b0);
      chk(gd, 1'b0);
      ac = 1'b0;
      step(DET + 20);
      chk(dis, 1'b1);
      // Second timer expiry turns the discharge half off, dc flag stays
      step(DET);
      chk(dis, 1'b0);
      chk(dcd, 1'b1);
      ac = 1'b1;
      fb = 3000;
      vcc = 29000;
      step(10);
      chk(flt, 1'b1);
      chk(gd, 1'b0);
      fb = 300;
      step(GTO + 10);
      chk(flt, 1'b1);
      fb = 3000;
      step(10);
      chk(off, 1'b0);
      therm = 1'b1;
      step(5);
      chk(off, 1'b1);
      end_sim();
   end
endmodule : test_offline_startup_supervisor
